/* File: src/rmpt_pkg.sv */
// Constants, timing counts, register map and types of the redriver mode and power timing block.
// Assumes a single 250 MHz system clock; all times are converted to cycles here.
package rmpt_pkg;
   localparam int CLK_MHZ         = 250;
   // Times as printed
   localparam int T_IDLE_ENTRY_NS = 10;
   localparam int T_U1_EXIT_NS    = 6;
   localparam int T_U23_EXIT_US   = 10;
   localparam int T_RXDET_MS      = 12;
   localparam int T_AEQ_FULL_US   = 300;
   localparam int T_AEQ_FAST_US   = 60;
   localparam int T_PG_MS         = 25;
   localparam int T_CFG_HD_US     = 10;
   localparam int T_CTL_DB_MS     = 16;
   localparam int T_HPD_DB_MS     = 2;
   localparam int T_AUX_SW_NS     = 500;
   // Cycle counts; nominal and least round up, longest round down
   localparam int IDLE_ENTRY_CYC  = (T_IDLE_ENTRY_NS * CLK_MHZ + 999) / 1000;
   localparam int U1_EXIT_CYC     = (T_U1_EXIT_NS * CLK_MHZ + 999) / 1000;
   localparam int U23_EXIT_CYC    = T_U23_EXIT_US * CLK_MHZ;
   localparam int RXDET_CYC       = T_RXDET_MS * CLK_MHZ * 1000;
   localparam int AEQ_FULL_CYC    = T_AEQ_FULL_US * CLK_MHZ;
   localparam int AEQ_FAST_CYC    = T_AEQ_FAST_US * CLK_MHZ;
   localparam int SYNC_LAT        = 4;
   localparam int PG_CYC          = T_PG_MS * CLK_MHZ * 1000 - SYNC_LAT;
   localparam int CFG_HD_CYC      = T_CFG_HD_US * CLK_MHZ;
   localparam int CTL_DB_CYC      = T_CTL_DB_MS * CLK_MHZ * 1000 - SYNC_LAT;
   localparam int HPD_DB_CYC      = T_HPD_DB_MS * CLK_MHZ * 1000;
   localparam int AUX_SW_CYC      = T_AUX_SW_NS * CLK_MHZ / 1000;
   // Register map, byte addresses
   localparam logic [7:0]  ADR_CTRL   = 8'h00;
   localparam logic [7:0]  ADR_STATUS = 8'h04;
   localparam logic [7:0]  ADR_STRAP  = 8'h08;
   localparam logic [1:0]  CTRL_RST   = 2'h0;
   // Link power state codes from the link monitor
   localparam logic [1:0]  PS_U0      = 2'h0;
   localparam logic [1:0]  PS_U1      = 2'h1;
   typedef enum logic [1:0] {EQ_FIXED, EQ_FAST, EQ_FULL} rmpt_eq_e;
   typedef enum logic [1:0] {LK_DISC, LK_ACTIVE, LK_IDLE, LK_EXIT} rmpt_link_e;
endpackage

/* File: src/rmpt_debounce.sv */
// Synchroniser and level debouncer for one mode or hot-plug pin.
// Assumes the pin is asynchronous; run is low until power good.
`timescale 1ns/1ps
module rmpt_debounce import rmpt_pkg::*; #(
   parameter int RISE_CYC = CTL_DB_CYC,
   parameter int FALL_CYC = CTL_DB_CYC
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // Control
   input  wire logic run,
   // Pin and result
   input  wire logic pin_in,
   output logic      level_q
);
   typedef struct packed {
      logic        s1;
      logic        s2;
      logic        lvl;
      logic [31:0] cnt;
   } rmpt_db_s;
   rmpt_db_s q, d;

   // Count while the synced level differs; held idle before power good
   always_comb begin
      d = q;
      d.s1 = pin_in;
      d.s2 = q.s1;
      if (!run) begin
         d.lvl = q.s2;
         d.cnt = 32'h0;
      end else if (q.s2 == q.lvl) begin
         d.cnt = 32'h0;
      end else if (q.cnt >= 32'(q.s2 ? RISE_CYC - 1 : FALL_CYC - 1)) begin
         d.lvl = q.s2;
         d.cnt = 32'h0;
      end else begin
         d.cnt = q.cnt + 32'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) q <= '0;
      else q <= d;
   end

   assign level_q = q.lvl;

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   AST_DB_SETTLE: assert property (run && $past(run) && $changed(q.lvl)
      |-> $past(q.cnt) == 32'(q.lvl ? RISE_CYC - 1 : FALL_CYC - 1))
      else $error("debounced level changed before its count");
   AST_DB_BOUND: assert property (q.cnt < 32'(RISE_CYC > FALL_CYC ? RISE_CYC : FALL_CYC))
      else $error("debounce counter beyond limit");
   CV_DB_FALL: cover property (run && $fell(q.lvl));
endmodule // rmpt_debounce

/* File: src/rmpt_core.sv */
// Top of the mode and power timing block: power good, straps, debounce, link timing,
// adaptive gain timing, sideband switch and a classic Wishbone register slave.
// Assumes analog detector outputs and pins are asynchronous; link_pstate is synchronous.
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module rmpt_core import rmpt_pkg::*; #(
   parameter int RXDET_CYCLES    = RXDET_CYC,
   parameter int AEQ_FULL_CYCLES = AEQ_FULL_CYC,
   parameter int AEQ_FAST_CYCLES = AEQ_FAST_CYC,
   parameter int PG_CYCLES       = PG_CYC,
   parameter int CTL_DB_CYCLES   = CTL_DB_CYC,
   parameter int HPD_DB_CYCLES   = HPD_DB_CYC
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Supply and straps (four-level codes)
   input  wire logic        supply_ok,
   input  wire logic [1:0]  cfg_select,
   input  wire logic [1:0]  rx_gain_select,
   input  wire logic [1:0]  superspeed_gain_select,
   input  wire logic [1:0]  display_gain_select,
   // Mode pins
   input  wire logic        mode_select_lo,
   input  wire logic        mode_select_hi,
   input  wire logic        flip_select,
   input  wire logic        hot_plug_detect_in,
   // Link detectors and monitor
   input  wire logic        rx_elec_idle,
   input  wire logic        rx_term_found,
   input  wire logic [1:0]  link_pstate,
   // Outputs
   output logic             power_good_q,
   output logic             strap_bias_en_q,
   output logic [7:0]       strap_q,
   output logic             rxdet_go_q,
   output logic             tx_elec_idle_q,
   output logic             lfps_fwd_q,
   output logic             adaptive_gain_search_q,
   output logic             gain_done_q,
   output logic             sideband_sw_on_q,
   output logic [3:0]       mode_pins_q
);
   typedef struct packed {
      logic        sup1, sup2, idl1, idl2, det1, det2;
      logic [7:0]  stp1, stp2, strap;
      logic        pg, bias;
      logic [31:0] pg_cnt, hd_cnt, ltmr, acnt;
      rmpt_link_e  st;
      logic        tx_idle, lfps, rxdet_go, busy, done, aux_on;
      rmpt_eq_e    mode;
      logic [3:0]  pins;
      logic        ack;
      logic [31:0] rdat;
   } rmpt_core_s;
   rmpt_core_s q, d;

   logic db_lo, db_hi, db_flip, db_hpd;
   logic wb_req;

   ////////////////////////////////////////////////////////////////////////////
   // Debouncers; upper select and hot plug have the short falling filter
   rmpt_debounce #(.RISE_CYC(CTL_DB_CYCLES), .FALL_CYC(CTL_DB_CYCLES)) u_db_lo (
      .clk_sys(clk_sys), .rst_b(rst_b), .run(q.pg),
      .pin_in(mode_select_lo), .level_q(db_lo));
   rmpt_debounce #(.RISE_CYC(CTL_DB_CYCLES), .FALL_CYC(HPD_DB_CYCLES)) u_db_hi (
      .clk_sys(clk_sys), .rst_b(rst_b), .run(q.pg),
      .pin_in(mode_select_hi), .level_q(db_hi));
   rmpt_debounce #(.RISE_CYC(CTL_DB_CYCLES), .FALL_CYC(CTL_DB_CYCLES)) u_db_flip (
      .clk_sys(clk_sys), .rst_b(rst_b), .run(q.pg),
      .pin_in(flip_select), .level_q(db_flip));
   rmpt_debounce #(.RISE_CYC(HPD_DB_CYCLES), .FALL_CYC(HPD_DB_CYCLES)) u_db_hpd (
      .clk_sys(clk_sys), .rst_b(rst_b), .run(q.pg),
      .pin_in(hot_plug_detect_in), .level_q(db_hpd));

   assign wb_req = wb_cyc_i && wb_stb_i && !q.ack;

   ////////////////////////////////////////////////////////////////////////////
   // Next state of the whole block
   always_comb begin
      d = q;
      // Two-flop synchronisers for pins and analog detectors
      d.sup1 = supply_ok;
      d.sup2 = q.sup1;
      d.idl1 = rx_elec_idle;
      d.idl2 = q.idl1;
      d.det1 = rx_term_found;
      d.det2 = q.det1;
      d.stp1 = {cfg_select, rx_gain_select, superspeed_gain_select, display_gain_select};
      d.stp2 = q.stp1;
      d.rxdet_go = 1'b0;

      // Power good delay; supply loss drops it at once
      if (!q.sup2) begin
         d.pg = 1'b0;
         d.pg_cnt = 32'h0;
      end else if (!q.pg) begin
         if (q.pg_cnt >= 32'(PG_CYCLES - 1)) begin
            d.pg = 1'b1;
         end else begin
            d.pg_cnt = q.pg_cnt + 32'h1;
         end
      end

      // Straps caught at power good, bias kept on through hold time
      // Supply loss reconnects bias at once, so straps are sensed again
      if (!q.pg || !d.pg) begin
         d.bias = 1'b1;
         d.hd_cnt = 32'h0;
         if (d.pg) d.strap = q.stp2;
      end else if (q.bias) begin
         if (q.hd_cnt >= 32'(CFG_HD_CYC - 1)) d.bias = 1'b0;
         else d.hd_cnt = q.hd_cnt + 32'h1;
      end

      // Sideband switch tracks debounced upper select next cycle
      d.aux_on = q.pg && db_hi;
      d.pins = {db_hpd, db_flip, db_hi, db_lo};

      // Link power state timing; all of it held until power good
      if (!q.pg) begin
         d.st = LK_DISC;
         d.ltmr = 32'h0;
         d.tx_idle = 1'b1;
         d.lfps = 1'b0;
      end else begin
         case (q.st)
            LK_DISC: begin
               d.tx_idle = 1'b1;
               d.lfps = 1'b0;
               if (q.det2) begin
                  d.st = LK_ACTIVE;
                  d.ltmr = 32'h0;
                  d.tx_idle = 1'b0;
               end else if (q.ltmr >= 32'(RXDET_CYCLES - 1)) begin
                  d.rxdet_go = 1'b1;
                  d.ltmr = 32'h0;
               end else begin
                  d.ltmr = q.ltmr + 32'h1;
               end
            end
            LK_ACTIVE: begin
               if (!q.det2) begin
                  d.st = LK_DISC;
                  d.ltmr = 32'h0;
               end else if (!q.idl2) begin
                  d.ltmr = 32'h0;
               end else if (q.ltmr >= 32'(IDLE_ENTRY_CYC - 1)) begin
                  d.st = LK_IDLE;
                  d.tx_idle = 1'b1;
                  d.lfps = 1'b0;
                  d.ltmr = 32'h0;
               end else begin
                  d.ltmr = q.ltmr + 32'h1;
               end
            end
            LK_IDLE: begin
               d.ltmr = 32'h0;
               if (!q.det2) d.st = LK_DISC;
               else if (!q.idl2) d.st = LK_EXIT;
            end
            LK_EXIT: begin
               // U0 code while idle is handled as the short U1 exit
               if (!q.det2) begin
                  d.st = LK_DISC;
                  d.ltmr = 32'h0;
               end else if (q.idl2) begin
                  d.st = LK_IDLE;
                  d.ltmr = 32'h0;
               end else if (q.ltmr >= 32'((link_pstate == PS_U1 || link_pstate == PS_U0)
                                          ? U1_EXIT_CYC - 1 : U23_EXIT_CYC - 1)) begin
                  d.st = LK_ACTIVE;
                  d.tx_idle = 1'b0;
                  d.lfps = 1'b1;
                  d.ltmr = 32'h0;
               end else begin
                  d.ltmr = q.ltmr + 32'h1;
               end
            end
            default: d.st = LK_DISC;
         endcase
      end

      // Adaptive gain search, started by each new device attach unless the mode is fixed
      if (!q.pg) begin
         d.busy = 1'b0;
         d.done = 1'b0;
         d.acnt = 32'h0;
      end else if (q.st == LK_DISC && d.st == LK_ACTIVE) begin
         d.busy = (q.mode != EQ_FIXED);
         d.done = (q.mode == EQ_FIXED); // Fixed gain needs no search
         d.acnt = 32'h0;
      end else if (q.busy) begin
         if (q.acnt >= 32'(q.mode == EQ_FULL ? AEQ_FULL_CYCLES - 1 : AEQ_FAST_CYCLES - 1)) begin
            d.busy = 1'b0;
            d.done = 1'b1;
         end else begin
            d.acnt = q.acnt + 32'h1;
         end
      end else if (q.st == LK_DISC) begin
         d.done = 1'b0;
      end

      // Wishbone: one-cycle ack, unmapped reads zero, writes ignored
      d.ack = wb_req;
      d.rdat = 32'h0;
      if (wb_req) begin
         if (wb_adr_i == ADR_CTRL) begin
            d.rdat = {30'h0, q.mode};
            if (wb_we_i && wb_sel_i[0] && !q.busy) begin
               // Mode writes are dropped while a search is running
               if (wb_dat_i[1:0] == 2'h1) d.mode = EQ_FAST;
               else if (wb_dat_i[1:0] == 2'h2) d.mode = EQ_FULL;
               else d.mode = EQ_FIXED;
            end
         end else if (wb_adr_i == ADR_STATUS) begin
            d.rdat = {18'h0, q.pins, q.aux_on, q.done, q.busy, q.st,
                      q.lfps, q.tx_idle, q.bias, q.pg, q.sup2};
         end else if (wb_adr_i == ADR_STRAP) begin
            d.rdat = {24'h0, q.strap};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         q <= '0;
         q.mode <= rmpt_eq_e'(CTRL_RST);
         q.st <= LK_DISC;
         q.tx_idle <= 1'b1;
         q.bias <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from state flops
   assign wb_dat_o = q.rdat;
   assign wb_ack_o = q.ack;
   assign power_good_q = q.pg;
   assign strap_bias_en_q = q.bias;
   assign strap_q = q.strap;
   assign rxdet_go_q = q.rxdet_go;
   assign tx_elec_idle_q = q.tx_idle;
   assign lfps_fwd_q = q.lfps;
   assign adaptive_gain_search_q = q.busy;
   assign gain_done_q = q.done;
   assign sideband_sw_on_q = q.aux_on;
   assign mode_pins_q = q.pins;

   ////////////////////////////////////////////////////////////////////////////
   localparam int A_IDLE = IDLE_ENTRY_CYC + 1;
   localparam int A_U1   = U1_EXIT_CYC + 1;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   AST_RXDET_INTVL: assert property (q.st == LK_DISC |-> q.ltmr < 32'(RXDET_CYCLES))
      else $error("receiver detect interval overrun");
   AST_IDLE_ENTRY: assert property (q.pg && q.st == LK_ACTIVE && q.det2 && q.idl2
      && q.ltmr == 32'h0 |-> ##[1:A_IDLE] (q.tx_idle || !q.idl2 || !q.det2))
      else $error("output idle entry late");
   AST_U1_EXIT: assert property (q.pg && q.st == LK_EXIT && q.ltmr == 32'h0
      && link_pstate == PS_U1 |-> ##[1:A_U1] (q.lfps || q.st != LK_EXIT))
      else $error("U1 exit late");
   AST_U23_EXIT: assert property (q.st == LK_EXIT |-> q.ltmr < 32'(U23_EXIT_CYC))
      else $error("U2/U3 exit timer overrun");
   AST_AEQ_FULL: assert property (q.busy && q.mode == EQ_FULL
      |-> q.acnt < 32'(AEQ_FULL_CYCLES))
      else $error("full search too long");
   AST_AEQ_FAST: assert property (q.busy && q.mode == EQ_FAST
      |-> q.acnt < 32'(AEQ_FAST_CYCLES))
      else $error("fast search too long");
   AST_AEQ_DONE: assert property ($fell(q.busy) && q.pg |-> q.done)
      else $error("search ended without done");
   AST_PG_DELAY: assert property (!q.pg |-> q.pg_cnt < 32'(PG_CYCLES))
      else $error("power good late");
   AST_STRAP_LATCH: assert property ($rose(q.pg) |-> q.strap == $past(q.stp2))
      else $error("straps not caught at power good");
   AST_BIAS_HOLD: assert property (!q.bias |-> q.pg && q.hd_cnt == 32'(CFG_HD_CYC - 1))
      else $error("bias dropped before hold time");
   AST_AUX_SW: assert property (q.pg && $changed(db_hi)
      |=> q.aux_on == $past(db_hi))
      else $error("sideband switch did not follow");
   AST_HELD_PG: assert property (!q.pg |=> q.st == LK_DISC && !q.busy)
      else $error("link logic running before power good");
   AST_WB_ACK: assert property (wb_req |=> q.ack ##1 !q.ack)
      else $error("bus ack not a single cycle");
   CV_RXDET: cover property (q.rxdet_go);
   CV_U_EXIT: cover property (q.st == LK_EXIT ##1 q.st == LK_ACTIVE);
   CV_AEQ: cover property ($rose(q.done) && q.mode == EQ_FULL);
   CV_AUX: cover property ($rose(q.aux_on));
endmodule // rmpt_core

/* File: tb/rmpt_host_model.sv */
// Behavioural host side: supply, strap resistors, mode pins and USB link detectors.
// Assumes clk_sys is the core clock; every pin change lands just after a rising edge.
`timescale 1ns/1ps
module rmpt_host_model import rmpt_pkg::*; #(
   parameter int         OVERLAP_CYC = 1000,  // 4 us at 250 MHz
   parameter logic [7:0] STRAP_VAL   = 8'hA5
) (
   // Clock
   input  wire logic  clk_sys,
   // Supply and straps
   output logic       supply_ok,
   output logic [1:0] cfg_select,
   output logic [1:0] rx_gain_select,
   output logic [1:0] superspeed_gain_select,
   output logic [1:0] display_gain_select,
   // Mode pins
   output logic       mode_select_lo,
   output logic       mode_select_hi,
   output logic       flip_select,
   output logic       hot_plug_detect_in,
   // Link detectors
   output logic       rx_elec_idle,
   output logic       rx_term_found,
   output logic [1:0] link_pstate
);
   ////////////////////////////////////////////////////////////////////////////////
   // Straps set before supply and never moved, so setup and hold are met
   initial begin
      {cfg_select, rx_gain_select, superspeed_gain_select, display_gain_select} = STRAP_VAL;
      supply_ok = 1'b0;
      {mode_select_lo, mode_select_hi, flip_select, hot_plug_detect_in} = 4'h0;
      rx_elec_idle = 1'b0;
      rx_term_found = 1'b0;
      link_pstate = PS_U0;
   end
   // Supply ramp
   task power(input logic v);
      @(posedge clk_sys);
      supply_ok <= v;
   endtask
   // One mode pin: 0 lower, 1 upper, 2 flip, 3 hot plug
   task pin(input int which, input logic v);
      @(posedge clk_sys);
      case (which)
         0: mode_select_lo <= v;
         1: mode_select_hi <= v;
         2: flip_select <= v;
         default: hot_plug_detect_in <= v;
      endcase
   endtask
   // Lower select first; held alone for OVERLAP_CYC + 1 cycles before the upper one follows
   task set_mode(input logic lo, input logic hi);
      pin(0, lo);
      repeat (OVERLAP_CYC) @(posedge clk_sys);
      pin(1, hi);
   endtask
   // Far termination, idle detector and power state code
   task link(input logic term, input logic idle, input logic [1:0] ps);
      @(posedge clk_sys);
      rx_term_found <= term;
      rx_elec_idle <= idle;
      link_pstate <= ps;
   endtask
endmodule // rmpt_host_model

/* File: tb/tb_redriver_mode_power_timing.sv */
// Self-checking bench: Wishbone master tasks plus host model pin and link sequences.
// Assumes shortened counts on the core for detect, search, power good and debounce; the other expected times use the package counts.
`timescale 1ns/1ps
module tb_redriver_mode_power_timing import rmpt_pkg::*;;
   localparam int RXD = 200;
   localparam int FULL = 40 + 60;
   localparam int FAST = 40;
   localparam int PG = 50;
   localparam int CDB = 64;
   localparam int HDB = 32;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_o, q;
   logic wb_ack_o, supply_ok, mode_select_lo, mode_select_hi, flip_select, hot_plug_detect_in;
   logic [1:0] cfg_select, rx_gain_select, superspeed_gain_select, display_gain_select, link_pstate;
   logic rx_elec_idle, rx_term_found, power_good_q, strap_bias_en_q, rxdet_go_q, tx_elec_idle_q;
   logic lfps_fwd_q, adaptive_gain_search_q, gain_done_q, sideband_sw_on_q;
   logic [7:0] strap_q;
   logic [3:0] mode_pins_q;
   int failures = 0, total_checks = 0, n;
   int mode_tab[3] = '{2, 1, 0};
   int lim_tab[3] = '{FULL, FAST, 8};
   // Watched outputs: 0 pg, 1 bias, 2 rxdet, 3 idle, 4 lfps, 5 done, 6 switch, 7-10 pins, 11 busy
   wire logic [11:0] obs = {adaptive_gain_search_q, mode_pins_q, sideband_sw_on_q, gain_done_q,
                            lfps_fwd_q, tx_elec_idle_q, rxdet_go_q, strap_bias_en_q, power_good_q};
   ////////////////////////////////////////////////////////////////////////////////
   always #2 clk_sys = ~clk_sys;
   rmpt_core #(.RXDET_CYCLES(RXD), .AEQ_FULL_CYCLES(FULL), .AEQ_FAST_CYCLES(FAST),
      .PG_CYCLES(PG), .CTL_DB_CYCLES(CDB), .HPD_DB_CYCLES(HDB)) i_rmpt_core (
      .clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
      .wb_dat_o, .wb_ack_o, .supply_ok, .cfg_select, .rx_gain_select, .superspeed_gain_select,
      .display_gain_select, .mode_select_lo, .mode_select_hi, .flip_select, .hot_plug_detect_in,
      .rx_elec_idle, .rx_term_found, .link_pstate, .power_good_q, .strap_bias_en_q, .strap_q,
      .rxdet_go_q, .tx_elec_idle_q, .lfps_fwd_q, .adaptive_gain_search_q, .gain_done_q,
      .sideband_sw_on_q, .mode_pins_q);
   rmpt_host_model i_rmpt_host_model (.clk_sys, .supply_ok, .cfg_select, .rx_gain_select,
      .superspeed_gain_select, .display_gain_select, .mode_select_lo, .mode_select_hi,
      .flip_select, .hot_plug_detect_in, .rx_elec_idle, .rx_term_found, .link_pstate);
   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task complete_run();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task chk_rng(input string nm, input int lo, input int hi, input int g);
      total_checks++;
      if (g < lo || g > hi) begin
         failures++;
         $display("unexpected %s exp %0d..%0d got %0d", nm, lo, hi, g);
      end
   endtask
   // Classic single cycle; held until ack is sampled high, then released
   task wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_sys);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
      do begin
         @(posedge clk_sys);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      if (k >= 20) begin
         failures++;
         $display("unexpected bus ack exp 1 got %b", wb_ack_o);
         complete_run();
      end
   endtask
   // Counts settled edges until a watched output reaches a level
   task wait_level(input int idx, input logic v, input int lim);
      #1;
      n = 0;
      while (obs[idx] !== v && n < lim) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n >= lim) begin
         failures++;
         $display("unexpected output %0d exp %b got %b", idx, v, obs[idx]);
         complete_run();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      wb_xfer(0, ADR_STATUS, 32'h0);
      chk("status reset", 32'h0000_000C, q);
      wb_xfer(0, ADR_CTRL, 32'h0);
      chk("ctrl reset", {30'h0, CTRL_RST}, q);
      wb_xfer(1, 8'h10, 32'hFFFF_FFFF);
      wb_xfer(0, 8'h10, 32'h0);
      chk("unmapped", 32'h0, q);
      i_rmpt_host_model.power(1'b1);
      wait_level(0, 1'b1, PG + 20);
      chk_rng("pg delay", PG, PG + 5, n);
      chk("strap", 32'h0000_00A5, {24'h0, strap_q});
      wait_level(1, 1'b0, CFG_HD_CYC + 50);
      chk_rng("bias hold", CFG_HD_CYC - 2, CFG_HD_CYC + 2, n);
      wait_level(2, 1'b1, RXD + 10);
      @(posedge clk_sys);
      wait_level(2, 1'b1, RXD + 10);
      chk_rng("rxdet interval", RXD - 2, RXD - 1, n);
      // Gain modes: full, fast, fixed; a write while busy must not land
      for (int i = 0; i < 3; i++) begin
         i_rmpt_host_model.link(1'b0, 1'b0, PS_U0);
         wait_level(5, 1'b0, 20);
         wb_xfer(1, ADR_CTRL, mode_tab[i]);
         i_rmpt_host_model.link(1'b1, 1'b0, PS_U0);
         if (i < 2) begin
            wait_level(11, 1'b1, 20);
            wb_xfer(1, ADR_CTRL, 32'h3);
         end
         wb_xfer(0, ADR_CTRL, 32'h0);
         chk("ctrl mode", mode_tab[i], q);
         wait_level(5, 1'b1, lim_tab[i] + 20);
         chk_rng("gain time", lim_tab[i] - 12, lim_tab[i], n);
      end
      i_rmpt_host_model.link(1'b1, 1'b1, PS_U0);
      wait_level(3, 1'b1, 20);
      chk_rng("idle entry", IDLE_ENTRY_CYC + 1, IDLE_ENTRY_CYC + 3, n);
      i_rmpt_host_model.link(1'b1, 1'b0, PS_U1);
      wait_level(4, 1'b1, 20);
      chk_rng("u1 exit", U1_EXIT_CYC + 2, U1_EXIT_CYC + 4, n);
      i_rmpt_host_model.link(1'b1, 1'b1, PS_U0);
      wait_level(3, 1'b1, 20);
      i_rmpt_host_model.link(1'b1, 1'b0, 2'h2);
      wait_level(4, 1'b1, U23_EXIT_CYC + 20);
      chk_rng("u2 exit", U23_EXIT_CYC + 2, U23_EXIT_CYC + 4, n);
      // Mode pins, sideband switch and hot plug
      i_rmpt_host_model.set_mode(1'b1, 1'b1);
      wait_level(8, 1'b1, CDB + 20);
      chk_rng("upper rise", CDB, CDB + 5, n);
      wait_level(6, 1'b1, AUX_SW_CYC);
      chk_rng("switch on", 0, 2, n);
      chk("lower level", 32'h1, {31'h0, obs[7]});
      i_rmpt_host_model.set_mode(1'b0, 1'b0);
      wait_level(8, 1'b0, HDB + 20);
      chk_rng("upper fall", HDB, HDB + 5, n);
      wait_level(6, 1'b0, AUX_SW_CYC);
      chk_rng("switch off", 0, 2, n);
      i_rmpt_host_model.pin(3, 1'b1);
      wait_level(10, 1'b1, HDB + 20);
      i_rmpt_host_model.pin(3, 1'b0);
      wait_level(10, 1'b0, HDB + 20);
      chk_rng("hot plug fall", HDB, HDB + 5, n);
      i_rmpt_host_model.pin(2, 1'b1);
      wait_level(9, 1'b1, CDB + 20);
      chk_rng("flip rise", CDB, CDB + 5, n);
      wb_xfer(0, ADR_STATUS, 32'h0);
      chk("status pins", 32'h4, {28'h0, q[13:10]});
      complete_run();
   end
endmodule // tb_redriver_mode_power_timing
